// File: ocmp_channel.v
// Output compare channel with register port, PWM and fault handling
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ocmp_map.vh"

// How it works
// - Timebase bit set picks third timer
// - Timer compared against one or two values
// - Match changes pin, may raise interrupt
// - Mode zero hands pin to port logic
// - Mode 001: low, match forces high
// - Mode 010: high, match forces low
// - Mode 011: match inverts pin, both edges
// - Mode 100: single pulse, falling interrupt
// - Mode 101: pulse train, falling interrupts
// - Mode 110: PWM, fault ignored, no interrupt
// - Mode 111: PWM, fault falling edge interrupts
// - Fault status set on fault, hardware cleared
// - Idle stop bit halts channel in idle
// - Unimplemented control bits read as zero
module ocmp_channel #(
  parameter WIDTH = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [15:0] bus_rdata,
  input wire [WIDTH-1:0] second_timer,
  input wire [WIDTH-1:0] third_timer,
  input wire second_period,
  input wire third_period,
  input wire cpu_idle,
  input wire fault_input_a,
  input wire gpio_out,
  input wire gpio_oe,
  output reg compare_output_pin,
  output reg compare_output_oe,
  output reg irq
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg [2:0] mode_reg; // Compare mode field
  reg [2:0] mode_prev_reg; // Mode seen last cycle, for entry detect
  reg tsel_reg; // Timebase select bit
  reg idle_stop_reg; // Idle stop bit
  reg fault_reg; // Fault status bit
  reg [WIDTH-1:0] pri_reg; // Primary compare value
  reg [WIDTH-1:0] sec_reg; // Secondary compare value
  reg [WIDTH-1:0] duty_reg; // Active PWM duty
  reg pin_reg; // Internal pin state
  reg done_reg; // Single pulse finished
  reg hit_p_reg; // Primary match seen last cycle
  reg hit_s_reg; // Secondary match seen last cycle
  reg [1:0] stat_reg; // Sticky interrupt status
  reg [1:0] mask_reg; // Interrupt mask
  reg flt_s1_reg; // Fault synchroniser stage one
  reg flt_s2_reg; // Fault synchroniser stage two
  reg flt_q_reg; // Previous synchronised fault level

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // True for both PWM modes
  function is_pwm;
    input [2:0] m;
    begin
      is_pwm = (m == `OCMP_M_PWM) || (m == `OCMP_M_PWMF);
    end
  endfunction

  wire [WIDTH-1:0] tmr; // Selected timer value
  wire period; // Selected timer period boundary
  wire [WIDTH-1:0] sec_tgt; // Falling edge target
  wire hit_p;
  wire hit_s;
  wire ev_p; // Primary match event, once per equal run
  wire ev_s; // Secondary match event
  wire halted; // Channel frozen in idle
  wire mode_chg; // First cycle of a new mode
  wire flt_fall; // Synchronised fault falling edge
  wire wr_stat;
  wire wr_ctrl;

  assign tmr = tsel_reg ? third_timer : second_timer;
  assign period = tsel_reg ? third_period : second_period;
  // PWM falls on the buffered duty, pulse modes on secondary
  assign sec_tgt = is_pwm(mode_reg) ? duty_reg : sec_reg;
  assign hit_p = (tmr == pri_reg);
  assign hit_s = (tmr == sec_tgt);
  // A prescaled timer rests on one value for many cycles, so only
  // the first cycle of equality counts as a match
  assign ev_p = hit_p & ~hit_p_reg;
  assign ev_s = hit_s & ~hit_s_reg;
  assign halted = idle_stop_reg & cpu_idle;
  assign mode_chg = (mode_reg != mode_prev_reg);
  assign flt_fall = flt_q_reg & ~flt_s2_reg;
  assign wr_ctrl = bus_wr && (bus_addr == `OCMP_CTRL_OFS);
  assign wr_stat = bus_wr && (bus_addr == `OCMP_STAT_OFS);

  // ****************************************************************
  // Pin next state
  // ****************************************************************
  reg pin_next;
  reg done_next;
  reg edge_ev; // Interrupting pin edge
  reg fault_next;
  reg fault_ev;
  // Mode behaviour, one branch per compare mode; the two PWM modes share one
  always @*
  begin
    pin_next = pin_reg;
    done_next = done_reg;
    fault_next = fault_reg;
    fault_ev = 1'b0;
    if (mode_chg)
    begin
      // Entry values of each mode
      done_next = 1'b0;
      fault_next = 1'b0;
      case (mode_reg)
        `OCMP_M_RISE: pin_next = 1'b0;
        `OCMP_M_FALL: pin_next = 1'b1;
        `OCMP_M_TOGGLE: pin_next = pin_reg;
        `OCMP_M_SINGLE: pin_next = 1'b0;
        `OCMP_M_CONT: pin_next = 1'b0;
        `OCMP_M_PWM: pin_next = (pri_reg != `OCMP_CMP_RST);
        `OCMP_M_PWMF: pin_next = (pri_reg != `OCMP_CMP_RST);
        default: pin_next = 1'b0;
      endcase
    end
    else
    begin
      case (mode_reg)
        `OCMP_M_RISE:
        begin
          if (ev_p)
            pin_next = 1'b1;
        end
        `OCMP_M_FALL:
        begin
          if (ev_p)
            pin_next = 1'b0;
        end
        `OCMP_M_TOGGLE:
        begin
          if (ev_p)
            pin_next = ~pin_reg;
        end
        `OCMP_M_SINGLE:
        begin
          // One pulse, then the channel stays low until re-entered
          if (!done_reg && ev_p && !pin_reg)
            pin_next = 1'b1;
          else if (!done_reg && ev_s && pin_reg)
          begin
            pin_next = 1'b0;
            done_next = 1'b1;
          end
        end
        `OCMP_M_CONT:
        begin
          if (ev_p && !pin_reg)
            pin_next = 1'b1;
          else if (ev_s && pin_reg)
            pin_next = 1'b0;
        end
        `OCMP_M_PWM, `OCMP_M_PWMF:
        begin
          // Boundary restarts the cycle; a zero duty keeps pin low
          if (period)
            pin_next = (sec_reg != `OCMP_CMP_RST);
          else if (ev_s)
            pin_next = 1'b0;
          if (mode_reg == `OCMP_M_PWMF)
          begin
            if (flt_fall)
            begin
              fault_next = 1'b1;
              fault_ev = 1'b1;
            end
            else if (period && flt_s2_reg)
              fault_next = 1'b0;
            if (fault_next)
              pin_next = 1'b0;
          end
        end
        default: pin_next = pin_reg;
      endcase
    end
    // Interrupting edges per mode; entry itself never interrupts
    edge_ev = 1'b0;
    if (!mode_chg)
    begin
      case (mode_reg)
        `OCMP_M_RISE: edge_ev = pin_next & ~pin_reg;
        `OCMP_M_FALL: edge_ev = ~pin_next & pin_reg;
        `OCMP_M_TOGGLE: edge_ev = pin_next ^ pin_reg;
        `OCMP_M_SINGLE: edge_ev = ~pin_next & pin_reg;
        `OCMP_M_CONT: edge_ev = ~pin_next & pin_reg;
        default: edge_ev = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Fault synchroniser
  // ****************************************************************
  // Two stages; only the second stage feeds the edge detector
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      flt_s1_reg <= 1'b1;
      flt_s2_reg <= 1'b1;
      flt_q_reg <= 1'b1;
    end
    else
    begin
      flt_s1_reg <= fault_input_a;
      flt_s2_reg <= flt_s1_reg;
      flt_q_reg <= flt_s2_reg;
    end
  end

  // ****************************************************************
  // Register writes and channel state
  // ****************************************************************
  // Control writes take effect at once; software is expected to
  // stop the timer first, otherwise a match may be missed
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_reg <= `OCMP_MODE_RST;
      mode_prev_reg <= `OCMP_MODE_RST;
      tsel_reg <= 1'b0;
      idle_stop_reg <= 1'b0;
      fault_reg <= 1'b0;
      pri_reg <= `OCMP_CMP_RST;
      sec_reg <= `OCMP_CMP_RST;
      duty_reg <= `OCMP_CMP_RST;
      pin_reg <= 1'b0;
      done_reg <= 1'b0;
      hit_p_reg <= 1'b0;
      hit_s_reg <= 1'b0;
      stat_reg <= `OCMP_IRQ_RST;
      mask_reg <= `OCMP_IRQ_RST;
    end
    else
    begin
      // Register port writes
      if (wr_ctrl)
      begin
        mode_reg <= bus_wdata[`OCMP_MODE_MSB:`OCMP_MODE_LSB];
        tsel_reg <= bus_wdata[`OCMP_TSEL_BIT];
        idle_stop_reg <= bus_wdata[`OCMP_IDLE_BIT];
      end
      if (bus_wr && (bus_addr == `OCMP_PRI_OFS))
        pri_reg <= bus_wdata[WIDTH-1:0];
      if (bus_wr && (bus_addr == `OCMP_SEC_OFS))
        sec_reg <= bus_wdata[WIDTH-1:0];
      if (bus_wr && (bus_addr == `OCMP_MASK_OFS))
        mask_reg <= bus_wdata[1:0];
      // Channel state freezes while halted in idle
      if (!halted)
      begin
        mode_prev_reg <= mode_reg;
        pin_reg <= pin_next;
        done_reg <= done_next;
        fault_reg <= fault_next;
        hit_p_reg <= hit_p;
        hit_s_reg <= hit_s;
        if (is_pwm(mode_reg) && (period || mode_chg))
          duty_reg <= sec_reg;
      end
      // Sticky status: write one clears, a new event wins
      stat_reg[`OCMP_IRQ_EDGE_BIT] <= (!halted && edge_ev) ||
        (stat_reg[`OCMP_IRQ_EDGE_BIT] &&
         !(wr_stat && bus_wdata[`OCMP_IRQ_EDGE_BIT]));
      stat_reg[`OCMP_IRQ_FLT_BIT] <= (!halted && fault_ev) ||
        (stat_reg[`OCMP_IRQ_FLT_BIT] &&
         !(wr_stat && bus_wdata[`OCMP_IRQ_FLT_BIT]));
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Pin, enable and interrupt are registered copies
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      compare_output_pin <= 1'b0;
      compare_output_oe <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (mode_reg == `OCMP_M_OFF)
      begin
        compare_output_pin <= gpio_out;
        compare_output_oe <= gpio_oe;
      end
      else
      begin
        // A halted channel must show its frozen level, not a match
        compare_output_pin <= halted ? pin_reg : pin_next;
        compare_output_oe <= 1'b1;
      end
      irq <= |(stat_reg & mask_reg);
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_sys)
  begin
    if (rst)
      bus_rdata <= 16'h0000;
    else if (!bus_rd)
      bus_rdata <= 16'h0000;
    else if (bus_addr == `OCMP_CTRL_OFS)
      bus_rdata <= {2'h0, idle_stop_reg, 8'h00, fault_reg, tsel_reg,
                    mode_reg};
    else if (bus_addr == `OCMP_PRI_OFS)
      bus_rdata <= pri_reg;
    else if (bus_addr == `OCMP_SEC_OFS)
      bus_rdata <= sec_reg;
    else if (bus_addr == `OCMP_STAT_OFS)
      bus_rdata <= {14'h0000, stat_reg};
    else if (bus_addr == `OCMP_MASK_OFS)
      bus_rdata <= {14'h0000, mask_reg};
    else
      bus_rdata <= 16'h0000;
  end

endmodule // ocmp_channel
`default_nettype wire

// File: ocmp_chk.sv
// Port checker of the output compare channel
`timescale 1ns/10ps
`default_nettype none
`include "ocmp_map.vh"
// ****************
// Port checker
// ****************
module ocmp_chk (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] bus_addr,
  input wire [15:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [15:0] bus_rdata,
  input wire cpu_idle,
  input wire gpio_out,
  input wire gpio_oe,
  input wire compare_output_pin,
  input wire compare_output_oe,
  input wire irq
);
  // Mirror of written {idle, tsel, mode}; fault bit is not software's
  reg [4:0] ctl_reg;
  wire [2:0] md = ctl_reg[2:0];
  wire rd_ctl = bus_rd && bus_addr == `OCMP_CTRL_OFS;
  // Follow control writes
  always @(posedge clk_sys)
  begin
    if (rst)
      ctl_reg <= 5'h00;
    else if (bus_wr && bus_addr == `OCMP_CTRL_OFS)
      ctl_reg <= {bus_wdata[13], bus_wdata[3:0]};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_CTRL_RD: assert property ($past(rd_ctl) |->
    {bus_rdata[13], bus_rdata[3:0]} == ctl_reg) else $error("ctrl read");
  AST_RSVD: assert property ($past(rd_ctl) |->
    bus_rdata[15:14] == 2'h0 && bus_rdata[12:5] == 8'h00)
    else $error("reserved bits set");
  AST_FLT_MODE: assert property ($past(rd_ctl) && md != 3'h7
    && $past(md, 2) != 3'h7 |-> !bus_rdata[4]) else $error("fault bit");
  // Mode must have settled first, or the old mode's level is judged
  AST_OFF_PASS: assert property (md == 3'h0 && $past(md) == 3'h0
    && !$past(rst) |-> compare_output_pin == $past(gpio_out)
    && compare_output_oe == $past(gpio_oe)) else $error("port pass");
  AST_ON_DRIVE: assert property (md != 3'h0 && $past(md) != 3'h0
    |-> compare_output_oe) else $error("pin not driven");
  AST_RISE_ONLY: assert property (md == 3'h1 && $past(md, 3) == 3'h1
    |-> !$fell(compare_output_pin)) else $error("pin fell");
  AST_FALL_ONLY: assert property (md == 3'h2 && $past(md, 3) == 3'h2
    |-> !$rose(compare_output_pin)) else $error("pin rose");
  AST_HALT: assert property (ctl_reg[4] && md != 3'h0 && cpu_idle
    && $past(cpu_idle) && $past(ctl_reg, 3) == ctl_reg
    |-> $stable(compare_output_pin)) else $error("moved while halted");
  AST_IRQ_CLR: assert property ($fell(irq) |-> $past(bus_wr, 2))
    else $error("irq dropped without write");
  cover property (md == 3'h7 && $fell(compare_output_pin));
  cover property ($rose(irq));
  cover property (ctl_reg[4] && cpu_idle && md == 3'h5);
endmodule // ocmp_chk
bind ocmp_channel ocmp_chk u_chk (.*);
`default_nettype wire

// File: ocmp_load.sv
// Load on the compare pin, with a fault source
`timescale 1ns/10ps
`default_nettype none
// ****************
// Load model
// ****************
module ocmp_load (
  input wire logic clk_sys,
  input wire logic pin,
  input wire logic oe,
  input wire logic clr,
  input wire logic fault_on,
  output logic fault_input_a,
  output logic [7:0] rises,
  output logic [7:0] falls
);
  logic last; // Previous level seen
  // Fault line is active low, idle high
  assign fault_input_a = !fault_on;
  // Count only driven edges; a released pin says nothing
  always @(posedge clk_sys)
  begin
    last <= pin;
    if (clr)
      {rises, falls} <= 16'h0000;
    else if (oe && pin && !last)
      rises <= rises + 8'h01;
    else if (oe && !pin && last)
      falls <= falls + 8'h01;
  end
endmodule // ocmp_load
`default_nettype wire

// File: ocmp_map.vh
// Register offsets, field positions, reset values and mode codes
`ifndef OCMP_MAP_VH
`define OCMP_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OCMP_CTRL_OFS 8'h00
`define OCMP_PRI_OFS 8'h04
`define OCMP_SEC_OFS 8'h08
`define OCMP_STAT_OFS 8'h0c
`define OCMP_MASK_OFS 8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define OCMP_MODE_MSB 2
`define OCMP_MODE_LSB 0
`define OCMP_TSEL_BIT 3
`define OCMP_FLT_BIT 4
`define OCMP_IDLE_BIT 13

// ****************************************************************
// Interrupt status and mask fields
// ****************************************************************
`define OCMP_IRQ_EDGE_BIT 0
`define OCMP_IRQ_FLT_BIT 1

// ****************************************************************
// Reset values
// ****************************************************************
`define OCMP_MODE_RST 3'h0
`define OCMP_CMP_RST 16'h0000
`define OCMP_IRQ_RST 2'h0

// ****************************************************************
// Compare mode codes
// ****************************************************************
`define OCMP_M_OFF 3'h0
`define OCMP_M_RISE 3'h1
`define OCMP_M_FALL 3'h2
`define OCMP_M_TOGGLE 3'h3
`define OCMP_M_SINGLE 3'h4
`define OCMP_M_CONT 3'h5
`define OCMP_M_PWM 3'h6
`define OCMP_M_PWMF 3'h7

`endif

// File: testbench.sv
// Self-checking bench of the output compare channel
`timescale 1ns/10ps
`default_nettype none
`include "ocmp_map.vh"
// ****************
// Bench top
// ****************
module testbench;
  localparam int PER = 40; // Short period keeps the run brief
  logic clk_sys = 1'b0;
  logic rst, bus_wr, bus_rd, run, use3, cpu_idle, gpio_out, gpio_oe;
  logic clr, flt, prd;
  logic [7:0] bus_addr, rises, falls;
  logic [15:0] bus_wdata, tmr;
  wire [15:0] bus_rdata;
  wire pin, oe, irq, flt_n;
  integer n_errors = 0, n_checks = 0, k;
  always #12.5 clk_sys = ~clk_sys;
  // Timer stub: wraps at PER, parked at zero while stopped
  always @(posedge clk_sys)
  begin
    tmr <= (!run || tmr == PER - 1) ? 16'h0000 : tmr + 16'h0001;
    prd <= run && tmr == PER - 1;
  end
  // Unselected timer sits at a value that never matches
  ocmp_channel u_dut (.clk_sys(clk_sys), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .second_timer(use3 ? 16'h7777 : tmr),
    .third_timer(use3 ? tmr : 16'h7777), .second_period(prd && !use3),
    .third_period(prd && use3), .cpu_idle(cpu_idle), .fault_input_a(flt_n),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .compare_output_pin(pin),
    .compare_output_oe(oe), .irq(irq));
  ocmp_load u_load (.clk_sys(clk_sys), .pin(pin), .oe(oe), .clr(clr),
    .fault_on(flt), .fault_input_a(flt_n), .rises(rises), .falls(falls));
  task automatic chk(input [15:0] s, input [15:0] e, input string nm);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input [7:0] a, input [15:0] d);
    @(posedge clk_sys);
    {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [15:0] e, input string nm);
    @(posedge clk_sys);
    {bus_addr, bus_rd} <= {a, 1'b1};
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e, nm);
  endtask
  // New mode with the timer stopped, then counts cleared and timer started
  task automatic go(input [15:0] c, input t3);
    @(posedge clk_sys);
    {run, use3} <= {1'b0, t3};
    wr(`OCMP_CTRL_OFS, c);
    clr <= 1'b1;
    @(posedge clk_sys);
    {clr, run} <= 2'h1;
  endtask
  task automatic wpin(input v, input string nm);
    for (int i = 0; i < 3 * PER && pin !== v; i++)
      @(posedge clk_sys) #1;
    #1 chk(pin, v, nm);
    if (pin !== v)
      end_of_test();
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {rst, run, bus_wr, bus_rd, use3, cpu_idle, clr, flt} = 8'h80;
    {gpio_out, gpio_oe, bus_addr, bus_wdata} = 26'h3000000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`OCMP_CTRL_OFS, 16'h0000, "ctrl reset");
    chk({pin, oe}, 16'h0003, "port pass");
    wr(`OCMP_CTRL_OFS, 16'hffff);
    rd(`OCMP_CTRL_OFS, 16'h200f, "ctrl bits");
    rd(8'h20, 16'h0000, "unmapped");
    wr(`OCMP_PRI_OFS, 16'h0014);
    wr(`OCMP_SEC_OFS, 16'h001e);
    rd(`OCMP_SEC_OFS, 16'h001e, "secondary");
    wr(`OCMP_MASK_OFS, 16'h0002);
    go(16'h0009, 1'b1);
    wpin(1'b1, "rise on third");
    rd(`OCMP_STAT_OFS, 16'h0001, "rise event");
    chk(irq, 1'b0, "masked");
    wr(`OCMP_MASK_OFS, 16'h0003);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b1, "unmasked");
    wr(`OCMP_STAT_OFS, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0, "cleared");
    $display("Test one-shot done");
    go(16'h0002, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk(pin, 1'b1, "high entry");
    wpin(1'b0, "fall on second");
    rd(`OCMP_STAT_OFS, 16'h0001, "fall event");
    wr(`OCMP_STAT_OFS, 16'h0001);
    go(16'h0003, 1'b0);
    wpin(1'b1, "toggle up");
    wr(`OCMP_STAT_OFS, 16'h0001);
    wpin(1'b0, "toggle down");
    rd(`OCMP_STAT_OFS, 16'h0001, "toggle event");
    wr(`OCMP_STAT_OFS, 16'h0001);
    go(16'h0004, 1'b0);
    repeat (3 * PER) @(posedge clk_sys);
    chk({rises, falls}, 16'h0101, "one pulse");
    rd(`OCMP_STAT_OFS, 16'h0001, "pulse event");
    $display("Test edge modes done");
    // Free run, idle without stop, idle with stop
    for (k = 0; k < 3; k++)
    begin
      wr(`OCMP_STAT_OFS, 16'h0001);
      cpu_idle <= k > 0;
      go(k == 2 ? 16'h2005 : 16'h0005, 1'b0);
      repeat (4 * PER) @(posedge clk_sys);
      chk(rises, k == 2 ? 16'h0000 : 16'h0004, "train");
    end
    cpu_idle <= 1'b0;
    wr(`OCMP_STAT_OFS, 16'h0003);
    flt <= 1'b1;
    go(16'h0006, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk(pin, 1'b1, "pwm entry");
    repeat (4 * PER - 2) @(posedge clk_sys);
    chk(falls, 16'h0004, "pwm duty");
    flt <= 1'b0;
    rd(`OCMP_STAT_OFS, 16'h0000, "pwm quiet");
    wr(`OCMP_PRI_OFS, 16'h0000);
    // Rewriting the same mode is no entry, so pass through off first
    go(16'h0000, 1'b0);
    go(16'h0006, 1'b0);
    repeat (2) @(posedge clk_sys);
    #1 chk(pin, 1'b0, "pwm zero entry");
    $display("Test pulse and pwm done");
    wr(`OCMP_PRI_OFS, 16'h0014);
    go(16'h0007, 1'b0);
    repeat (PER + 2) @(posedge clk_sys);
    flt <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk(pin, 1'b0, "fault low");
    rd(`OCMP_CTRL_OFS, 16'h0017, "fault set");
    rd(`OCMP_STAT_OFS, 16'h0002, "fault event");
    chk(irq, 1'b1, "fault irq");
    @(posedge clk_sys) flt <= 1'b0;
    repeat (2 * PER) @(posedge clk_sys);
    rd(`OCMP_CTRL_OFS, 16'h0007, "fault gone");
    go(16'h0000, 1'b0);
    gpio_out <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk({pin, oe}, 16'h0001, "port again");
    $display("Test fault and port done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
